// >>> design/detector_pkg.sv
// Shared constants, register map and types for the overload and sag detector.
`default_nettype none

package detector_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets on the APB window.
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_FLAG_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] RD_CLR_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] VOLT_LIM_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] CURA_LIM_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] CURB_LIM_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] PWR_LIM_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] SAG_CYC_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] SAG_LVL_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] SAG_STAT_OFF = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned OVER_EN_BIT = 3;
  localparam int unsigned SAG_EN_BIT = 4;
  localparam int unsigned WAVE_EN_BIT = 5;
  localparam int unsigned FLAG_OV = 0;
  localparam int unsigned FLAG_OIA = 1;
  localparam int unsigned FLAG_OIB = 2;
  localparam int unsigned FLAG_OP = 3;
  localparam int unsigned FLAG_SAG = 4;
  localparam int unsigned NUM_FLAGS = 5;
  localparam int unsigned NUM_LIMITS = 4;
  localparam int unsigned ALIGN_BITS = 17;
  localparam int unsigned SAG_CYC_BITS = 8;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0001;
  localparam logic [15:0] LIM_RST = 16'hffff;
  localparam logic [15:0] SAG_CYC_RST = 16'h0000;
  localparam logic [15:0] SAG_LVL_RST = 16'h0000;
  localparam logic [NUM_FLAGS-1:0] IRQ_EN_RST = 5'h00;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic signed [23:0] voltage;
    logic signed [23:0] current_a;
    logic signed [23:0] current_b;
    logic signed [31:0] power;
  } sample_t;

  typedef enum logic [1:0] {
    SAG_IDLE = 2'b00,
    SAG_COUNT = 2'b01,
    SAG_HELD = 2'b11
  } sag_state_t;

endpackage

`default_nettype wire

// >>> design/over_limit_compare.sv
// Magnitude comparison of one instantaneous value against a 16-bit limit.
`default_nettype none

module over_limit_compare
  import detector_pkg::*;
(
  // Value, left aligned in 32 bits, and its limit
  input wire logic signed [31:0] value,
  input wire logic [15:0] limit,
  // Result
  output logic above
);

  logic [31:0] magnitude;
  logic [ALIGN_BITS-1:0] top;

  // The most negative value keeps its pattern, which reads as the right
  // unsigned magnitude, so no extra bit is needed.
  always_comb begin
    magnitude = value[31] ? 32'(-value) : 32'(value); // [R2]
    top = magnitude[31:32-ALIGN_BITS]; // [R4]
    above = top > {1'b0, limit}; // [R20]
  end

endmodule

`default_nettype wire

// >>> design/sag_detector.sv
// Half-cycle sag counter working on the instantaneous voltage waveform.
`default_nettype none

module sag_detector
  import detector_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic [15:0] level,
  input wire logic [SAG_CYC_BITS-1:0] period,
  // Waveform
  input wire logic sample_valid,
  input wire logic signed [23:0] voltage,
  input wire logic half_cycle,
  // Status
  output logic sag_event_q,
  output logic [SAG_CYC_BITS-1:0] count_q,
  output sag_state_t state_q
);

  localparam logic [SAG_CYC_BITS-1:0] CNT_MAX = '1;

  logic [23:0] magnitude;
  logic low;

  // Compare the top 17 bits of the magnitude with the sag level.
  always_comb begin
    magnitude = voltage[23] ? 24'(-voltage) : 24'(voltage);
    low = magnitude[23:24-ALIGN_BITS] < {1'b0, level}; // [R10] [R17]
  end

  // Count half-cycles; period is read live so a new value acts at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SAG_IDLE;
      count_q <= '0;
      sag_event_q <= 1'b0;
    end else begin
      sag_event_q <= 1'b0;
      if (!enable) begin // [R9]
        state_q <= SAG_IDLE;
        count_q <= '0;
      end else begin
        case (state_q)
          SAG_IDLE: begin
            if (sample_valid && low) begin
              state_q <= SAG_COUNT;
              count_q <= '0;
            end
          end
          SAG_COUNT: begin
            if (sample_valid && !low) begin
              state_q <= SAG_IDLE; // [R19]
              count_q <= '0;
            end else if (count_q >= period) begin // [R14] [R15]
              state_q <= SAG_HELD;
              sag_event_q <= 1'b1; // [R10]
            end else if (half_cycle && count_q != CNT_MAX) begin
              count_q <= count_q + 1'b1; // [R13]
            end
          end
          SAG_HELD: begin
            // One event per sag; wait for the voltage to recover.
            if (sample_valid && !low) begin
              state_q <= SAG_IDLE;
              count_q <= '0;
            end
          end
          default: begin
            state_q <= SAG_IDLE;
            count_q <= '0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/overload_and_sag_detector.sv
// Overload and voltage sag detector with APB register access.
//
// Implementation choices: register access over APB and the register addresses.
`default_nettype none

// Notes on behaviour
// [R1] Overload detect needs overload and waveform enables.
// [R2] Compare absolute waveform and power values.
// [R3] Four limit registers reset to all ones.
// [R4] Limits align with top 17 value bits.
// [R5] Overload sets both flag and read-clear bits.
// [R6] Reading read-clear register clears both copies.
// [R7] Overload interrupt only when its enable set.
// [R8] Each overload limit is sixteen bits.
// [R9] Sag detect needs sag and waveform enables.
// [R10] Sag after voltage low for programmed half-cycles.
// [R11] Sag bit sets on sag, clears on read.
// [R12] Sag period register sixteen bits, low eight used.
// [R13] Period counts half-cycles, maximum 255.
// [R14] Sag only once count reaches programmed period.
// [R15] New sag period applies immediately.
// [R16] Host zeroes sag level before changing period.
// [R17] Sag level sixteen bits, peak register scaling.
// [R18] Sag interrupt pulls pin low, off after reset.
// [R19] Voltage recovery restarts the half-cycle count.
// [R20] Overload only when strictly above the limit.
module overload_and_sag_detector
  import detector_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instantaneous waveform data path
  input wire sample_t sample,
  input wire logic half_cycle,
  // Interrupt pin, active low
  output logic irq_n
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [NUM_FLAGS-1:0] irq_en_q;
  logic [NUM_FLAGS-1:0] flag_q;
  logic [NUM_FLAGS-1:0] rd_clr_q;
  logic [15:0] limit_q [NUM_LIMITS];
  logic [15:0] sag_cyc_q;
  logic [15:0] sag_lvl_q;

  // ----------------------------------------------------------------------
  // Bus outputs.
  // ----------------------------------------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic irq_n_q;

  // ----------------------------------------------------------------------
  // Decoded access and detector signals.
  // ----------------------------------------------------------------------
  logic setup;
  logic wr_fire;
  logic rd_fire;
  logic [15:0] wdata16;
  logic wave_en;
  logic over_en;
  logic sag_en;
  logic [NUM_LIMITS-1:0] above;
  logic signed [31:0] aligned [NUM_LIMITS];
  logic [NUM_FLAGS-1:0] events;
  logic [NUM_FLAGS-1:0] clr_both;
  logic [NUM_FLAGS-1:0] clr_flag_only;
  logic sag_event;
  logic [SAG_CYC_BITS-1:0] sag_count;
  sag_state_t sag_state;

  // ----------------------------------------------------------------------
  // APB phase decode.
  // ----------------------------------------------------------------------

  // The answer is registered in the setup cycle, so every access takes
  // exactly one access cycle; writes and read side effects happen only at
  // the edge where pready is seen high.
  always_comb begin
    setup = psel && !penable;
    wr_fire = psel && penable && pready_q && pwrite;
    rd_fire = psel && penable && pready_q && !pwrite;
    wdata16 = pwdata[15:0];
  end

  // Enables; waveform enable gates both detectors.
  always_comb begin
    wave_en = ctrl_q[WAVE_EN_BIT];
    over_en = ctrl_q[OVER_EN_BIT] && wave_en; // [R1]
    sag_en = ctrl_q[SAG_EN_BIT] && wave_en; // [R9]
  end

  // ----------------------------------------------------------------------
  // Read mux and error decode.
  // ----------------------------------------------------------------------

  // Narrow registers sit in the low bits, except the sag state at bits 17:16; the rest read as zero.
  always_comb begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (paddr == CTRL_OFF) begin
      prdata_d[15:0] = ctrl_q;
    end else if (paddr == IRQ_EN_OFF) begin
      prdata_d[NUM_FLAGS-1:0] = irq_en_q;
    end else if (paddr == IRQ_FLAG_OFF) begin
      prdata_d[NUM_FLAGS-1:0] = flag_q;
    end else if (paddr == RD_CLR_OFF) begin
      prdata_d[NUM_FLAGS-1:0] = rd_clr_q;
    end else if (paddr == VOLT_LIM_OFF) begin
      prdata_d[15:0] = limit_q[FLAG_OV];
    end else if (paddr == CURA_LIM_OFF) begin
      prdata_d[15:0] = limit_q[FLAG_OIA];
    end else if (paddr == CURB_LIM_OFF) begin
      prdata_d[15:0] = limit_q[FLAG_OIB];
    end else if (paddr == PWR_LIM_OFF) begin
      prdata_d[15:0] = limit_q[FLAG_OP];
    end else if (paddr == SAG_CYC_OFF) begin
      prdata_d[15:0] = sag_cyc_q; // [R12]
    end else if (paddr == SAG_LVL_OFF) begin
      prdata_d[15:0] = sag_lvl_q;
    end else if (paddr == SAG_STAT_OFF) begin
      prdata_d[SAG_CYC_BITS-1:0] = sag_count;
      prdata_d[17:16] = sag_state;
    end else begin
      pslverr_d = 1'b1;
    end
  end

  // Bus answer registers; pready is high for the access cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= prdata_d;
        pslverr_q <= pslverr_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control and threshold registers.
  // ----------------------------------------------------------------------

  // Only byte lane 0 and 1 carry data; the strobes are honoured per lane.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      irq_en_q <= IRQ_EN_RST; // [R18]
      sag_cyc_q <= SAG_CYC_RST;
      sag_lvl_q <= SAG_LVL_RST;
    end else if (wr_fire) begin
      if (paddr == CTRL_OFF) begin
        if (pstrb[0]) ctrl_q[7:0] <= wdata16[7:0];
        if (pstrb[1]) ctrl_q[15:8] <= wdata16[15:8];
      end else if (paddr == IRQ_EN_OFF) begin
        if (pstrb[0]) irq_en_q <= wdata16[NUM_FLAGS-1:0];
      end else if (paddr == SAG_CYC_OFF) begin
        if (pstrb[0]) sag_cyc_q[7:0] <= wdata16[7:0]; // [R12] [R15]
        if (pstrb[1]) sag_cyc_q[15:8] <= wdata16[15:8];
      end else if (paddr == SAG_LVL_OFF) begin
        if (pstrb[0]) sag_lvl_q[7:0] <= wdata16[7:0]; // [R17]
        if (pstrb[1]) sag_lvl_q[15:8] <= wdata16[15:8];
      end
    end
  end

  // The four limits repeat per channel; the offsets step by one word.
  for (genvar g = 0; g < NUM_LIMITS; g++) begin : g_limit
    localparam logic [ADDR_W-1:0] OFF = ADDR_W'(VOLT_LIM_OFF + 4 * g);

    // Limits are held unsigned at full width and start at all ones, which only the most negative value exceeds.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        limit_q[g] <= LIM_RST; // [R3] [R8]
      end else if (wr_fire && paddr == OFF) begin
        if (pstrb[0]) limit_q[g][7:0] <= wdata16[7:0];
        if (pstrb[1]) limit_q[g][15:8] <= wdata16[15:8];
      end
    end

    over_limit_compare u_cmp (
      .value(aligned[g]),
      .limit(limit_q[g]),
      .above(above[g])
    );
  end

  // ----------------------------------------------------------------------
  // Overload comparison inputs.
  // ----------------------------------------------------------------------

  // Waveforms are shifted into the top of 32 bits, so the comparator's
  // top 17 bits are bits 23:7 of a waveform and 31:15 of the power.
  always_comb begin
    aligned[FLAG_OV] = {sample.voltage, 8'h00}; // [R4]
    aligned[FLAG_OIA] = {sample.current_a, 8'h00};
    aligned[FLAG_OIB] = {sample.current_b, 8'h00};
    aligned[FLAG_OP] = sample.power;
  end

  // ----------------------------------------------------------------------
  // Sag detector.
  // ----------------------------------------------------------------------

  // Only the low byte of the period register reaches the counter.
  sag_detector u_sag (
    .pclk(pclk),
    .presetn(presetn),
    .enable(sag_en),
    .level(sag_lvl_q),
    .period(sag_cyc_q[SAG_CYC_BITS-1:0]), // [R12] [R13]
    .sample_valid(sample.valid),
    .voltage(sample.voltage),
    .half_cycle(half_cycle),
    .sag_event_q(sag_event),
    .count_q(sag_count),
    .state_q(sag_state)
  );

  // ----------------------------------------------------------------------
  // Event collection and flag clearing.
  // ----------------------------------------------------------------------

  // Overload events are sampled only on a fresh waveform sample.
  always_comb begin
    events = '0;
    events[NUM_LIMITS-1:0] = (over_en && sample.valid) ? above : '0; // [R1]
    events[FLAG_SAG] = sag_event; // [R11]
  end

  // A read clears only what it returned, so an event that lands between
  // the setup and access cycles survives to the next read.
  always_comb begin
    clr_both = '0;
    clr_flag_only = '0;
    if (rd_fire && paddr == RD_CLR_OFF) begin
      clr_both = prdata_q[NUM_FLAGS-1:0]; // [R6]
    end
    if (wr_fire && paddr == IRQ_FLAG_OFF && pstrb[0]) begin
      clr_flag_only = wdata16[NUM_FLAGS-1:0];
    end
  end

  // Interrupt flag copy; set wins over any clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~(clr_both | clr_flag_only)) | events; // [R5]
    end
  end

  // Read-clear copy; only a read of itself clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_clr_q <= '0;
    end else begin
      rd_clr_q <= (rd_clr_q & ~clr_both) | events; // [R5] [R6] [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt pin.
  // ----------------------------------------------------------------------

  // The pin is a registered level so it never glitches on the flag logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(flag_q & irq_en_q); // [R7] [R18]
    end
  end

  // ----------------------------------------------------------------------
  // Output connections.
  // ----------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_n = irq_n_q;

endmodule

`default_nettype wire

// >>> tb/detector_monitor.sv
// Bus and interrupt checker bound to the detector top.
`default_nettype none

module detector_monitor
  import detector_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Waveform and interrupt
  input wire sample_t sample,
  input wire logic half_cycle,
  input wire logic irq_n
);
  logic [NUM_FLAGS-1:0] ien_q;
  logic [3:0] lim_wr_q;
  logic setup;
  logic acc_wr;

  // Setup and completed-write strobes as seen on the bus.
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready && pwrite;

  // Shadow of the interrupt enables, so the pin can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= IRQ_EN_RST;
    end else if (acc_wr && paddr == IRQ_EN_OFF) begin
      ien_q <= pwdata[NUM_FLAGS-1:0];
    end
  end

  // Limits written since reset; unwritten ones must read the reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_wr_q <= '0;
    end else if (acc_wr && paddr[7:4] == 4'h1) begin
      lim_wr_q[paddr[3:2]] <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Properties.
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  setup_ready_a: assert property (setup |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  bad_addr_a: assert property (setup && paddr > SAG_STAT_OFF
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property (setup && paddr <= SAG_STAT_OFF &&
    paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped refused");
  lim_reset_a: assert property (
    setup && !pwrite && paddr[7:4] == 4'h1 && !lim_wr_q[paddr[3:2]]
    |=> prdata == {16'h0, LIM_RST}) else $error("limit reset wrong");
  irq_cause_a: assert property ($fell(irq_n) |-> ien_q != '0)
    else $error("irq without enable");
  irq_mask_a: assert property (ien_q == '0 |=> irq_n)
    else $error("masked irq seen");
  irq_reset_a: assert property ($rose(presetn) |-> irq_n)
    else $error("irq active after reset");

  cover property ($fell(irq_n));
  cover property (pready && pslverr);
  cover property (psel && penable && pready && paddr == RD_CLR_OFF &&
    prdata != 32'h0);
endmodule

bind overload_and_sag_detector detector_monitor detector_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .sample, .half_cycle, .irq_n
);

`default_nettype wire

// >>> tb/apb_host.sv
// Host model: APB master that reaches the detector registers.
`default_nettype none

module apb_host
  import detector_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);

  // Idle bus from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end

  // One transfer; the request holds until pready is seen at an edge.
  // No wait limit here: a slave that never answers is caught by the
  // bench's cycle ceiling, which then fails the run.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  // A zero level during the change blocks new sags; a count already running still meets the new period.
  task automatic set_period(input logic [15:0] p, input logic [15:0] lvl);
    wr(SAG_LVL_OFF, 32'h0);
    wr(SAG_CYC_OFF, {16'h0, p});
    wr(SAG_LVL_OFF, {16'h0, lvl});
  endtask
endmodule

`default_nettype wire

// >>> tb/overload_and_sag_detector_tb.sv
// Self-checking bench for the overload and sag detector.
`default_nettype none

`define CHK(what, exp, got) begin check_count++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module overload_and_sag_detector_tb
  import detector_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n;
  logic half_cycle;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  sample_t sample;
  int miscompares, check_count, cycles;

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      complete_run();
    end
  end

  apb_host apb_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  overload_and_sag_detector overload_and_sag_detector_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .sample, .half_cycle, .irq_n);

  // --------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb_host_i.xfer(1'b0, a, 32'h0, q, e);
    `CHK($sformatf("reg %h", a), x, q)
    `CHK("bus error", 1'b0, e)
  endtask

  task automatic put(input sample_t s);
    @(posedge pclk);
    sample <= s;
    @(posedge pclk);
    sample.valid <= 1'b0;
  endtask

  task automatic half(input int n);
    repeat (n) begin
      @(posedge pclk);
      half_cycle <= 1'b1;
      @(posedge pclk);
      half_cycle <= 1'b0;
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  task automatic check_reset();
    logic [31:0] q;
    logic e;
    rd_chk(CTRL_OFF, {16'h0, CTRL_RST});
    rd_chk(IRQ_EN_OFF, 32'h0);
    for (int i = 0; i < NUM_LIMITS; i++) begin
      rd_chk(VOLT_LIM_OFF + 8'(4 * i), {16'h0, LIM_RST});
    end
    apb_host_i.xfer(1'b0, 8'h2c, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
  endtask

  // Upper half of the write word is dropped by 16-bit registers.
  task automatic check_limits();
    for (int i = 0; i < NUM_LIMITS; i++) begin
      apb_host_i.wr(VOLT_LIM_OFF + 8'(4 * i), 32'hffff_8000 | i);
      rd_chk(VOLT_LIM_OFF + 8'(4 * i), 32'h8000 | i);
    end
    apb_host_i.wr(SAG_CYC_OFF, 32'h0001_01ff);
    rd_chk(SAG_CYC_OFF, 32'h01ff);
  endtask

  // Equal to the limit stays quiet, one step above flags, either sign.
  task automatic check_overload();
    sample_t s;
    logic [31:0] m;
    apb_host_i.wr(CTRL_OFF, 32'h28);
    for (int i = 0; i < NUM_LIMITS; i++) begin
      apb_host_i.wr(VOLT_LIM_OFF + 8'(4 * i), 32'h0100);
      for (int k = 0; k < 2; k++) begin
        m = (32'h0100 + k) << (i == 3 ? 15 : 7);
        s = '0;
        s.valid = 1'b1;
        case (i)
          0: s.voltage = -24'(m);
          1: s.current_a = 24'(m);
          2: s.current_b = -24'(m);
          default: s.power = -m;
        endcase
        put(s);
        rd_chk(IRQ_FLAG_OFF, k ? 32'(1 << i) : 32'h0);
      end
      rd_chk(RD_CLR_OFF, 32'(1 << i));
      rd_chk(IRQ_FLAG_OFF, 32'h0);
    end
  endtask

  task automatic check_irq();
    sample_t s;
    s = '0;
    s.valid = 1'b1;
    s.voltage = 24'h7f_ffff;
    apb_host_i.wr(VOLT_LIM_OFF, 32'h0);
    apb_host_i.wr(CTRL_OFF, 32'h08);
    put(s);
    apb_host_i.wr(CTRL_OFF, 32'h20);
    put(s);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    apb_host_i.wr(CTRL_OFF, 32'h28);
    put(s);
    repeat (3) @(posedge pclk);
    `CHK("irq masked", 1'b1, irq_n)
    apb_host_i.wr(IRQ_EN_OFF, 32'h01);
    repeat (2) @(posedge pclk);
    `CHK("irq enabled", 1'b0, irq_n)
    rd_chk(RD_CLR_OFF, 32'h01);
  endtask

  task automatic check_sag();
    sample_t lo, hi;
    lo = '0;
    lo.valid = 1'b1;
    lo.voltage = 24'sh000800;
    hi = lo;
    hi.voltage = -24'sh010000;
    apb_host_i.wr(IRQ_EN_OFF, 32'h10);
    apb_host_i.wr(CTRL_OFF, 32'h10);
    apb_host_i.set_period(16'd3, 16'h0100);
    put(lo);
    half(4);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    apb_host_i.wr(CTRL_OFF, 32'h30);
    put(lo);
    half(2);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    half(1);
    // The event pulse and then the flag each take one more edge.
    repeat (2) @(posedge pclk);
    rd_chk(IRQ_FLAG_OFF, 32'h10);
    `CHK("sag irq", 1'b0, irq_n)
    rd_chk(RD_CLR_OFF, 32'h10);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    put(hi);
    put(lo);
    half(2);
    put(hi);
    put(lo);
    half(2);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    apb_host_i.set_period(16'd2, 16'h0100);
    rd_chk(IRQ_FLAG_OFF, 32'h10);
    rd_chk(SAG_STAT_OFF, 32'h0003_0002);
    // Writing ones to the flag register clears only that copy.
    apb_host_i.wr(IRQ_FLAG_OFF, 32'h10);
    rd_chk(IRQ_FLAG_OFF, 32'h0);
    rd_chk(RD_CLR_OFF, 32'h10);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset, then each scenario in turn.
  initial begin
    presetn = 1'b0;
    sample = '0;
    half_cycle = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check_reset();
    check_limits();
    check_overload();
    check_irq();
    check_sag();
    complete_run();
  end
endmodule

`default_nettype wire
